// ---- core/gpio_resp_pace.sv ----
// gpio pins, respiration clock generation and pace channel control
// assumes an apb master on CORE_CLK and pins sampled from outside
`timescale 1ns/10ps
`default_nettype none
`include "gpio_resp_params.svh"

module gpio_resp_pace
    import gpio_resp_pkg::*;
#(
    parameter int SETTLE_CLKS = 5000
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [3:0] PIN_IN,
    output logic [3:0] PIN_OUT,
    output logic [3:0] PIN_OE,
    input wire logic CLK_SOURCE_PIN,
    input wire logic CONVERSION_READY_N,
    output logic [3:0] PACE_CHAN_SEL,
    output logic PACE_AMP_POWER,
    output logic MOD_BLOCK_EN,
    output logic DEMOD_BLOCK_EN,
    output logic CH1_RESP_ONLY,
    output logic INT_OSC_SEL,
    output logic FILTER_SETTLED
);
    localparam int HALF64 = `CORE_CLK_HZ / (`FREQ_64K_HZ * 2);
    localparam int HALF32 = `CORE_CLK_HZ / (`FREQ_32K_HZ * 2);
    localparam int LATCH_CLKS = `FRAME_LATCH_CLKS;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
    logic clk_s1_q, clk_s2_q, clk_s3_q, clk_lvl_q;
    logic rdy_s1_q, rdy_s2_q, rdy_s3_q, rdy_lvl_q;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            // ready idles high; high stages avoid a false edge after reset
            rdy_s1_q <= 1'b1;
            rdy_s2_q <= 1'b1;
            rdy_s3_q <= 1'b1;
        end else if (CLK_EN) begin
            pin_s1_q <= PIN_IN;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            clk_s1_q <= CLK_SOURCE_PIN;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            rdy_s1_q <= CONVERSION_READY_N;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
        end
    end

    // a change counts once the second and third stages agree
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pin_lvl_q <= 4'h0;
            clk_lvl_q <= 1'b0;
            rdy_lvl_q <= 1'b1;
        end else if (CLK_EN) begin
            for (int i = 0; i < 4; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) begin
                    pin_lvl_q[i] <= pin_s3_q[i];
                end
            end
            if (clk_s2_q == clk_s3_q) begin
                clk_lvl_q <= clk_s3_q;
            end
            if (rdy_s2_q == rdy_s3_q) begin
                rdy_lvl_q <= rdy_s3_q;
            end
        end
    end

    assign INT_OSC_SEL = clk_lvl_q; // R20

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // strobe qualified by one register's byte address
    function automatic logic reg_hit(input logic strobe,
        input logic [11:0] addr, input logic [11:0] reg_addr);
        return strobe && (addr == reg_addr);
    endfunction : reg_hit

    // external and user modes take pins two to four from gpio control
    function automatic logic [3:0] taken_pins(input logic [1:0] mode);
        return (mode == `MODE_EXT || mode == `MODE_USER) ? 4'hE : 4'h0;
    endfunction : taken_pins

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    pin_ctrl_s pin_q;
    resp_mode_sel_s resp_q;
    logic [3:0] pace_sel_q;
    logic pace_pwr_q;
    logic [3:0] frame_q;
    logic [31:0] prdata_q;
    logic [3:0] pin_now;
    logic [3:0] forced_mask;
    logic wr_en, rd_en, addr_ok;

    // every register is a flop, so no wait states are needed
    assign PREADY = 1'b1;
    assign wr_en = PSEL && PENABLE && PWRITE && CLK_EN;
    assign rd_en = PSEL && !PENABLE && !PWRITE && CLK_EN;
    assign addr_ok = (PADDR == `ADDR_PIN_CTRL) || (PADDR == `ADDR_RESP_SET)
        || (PADDR == `ADDR_PACE_CTRL) || (PADDR == `ADDR_STATUS)
        || (PADDR == `ADDR_FRAME);
    // unmapped addresses answer with an error; writes there are dropped
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign PRDATA = prdata_q;

    // pins two to four leave gpio control in external and user modes
    assign forced_mask = taken_pins(resp_q.mode); // R5 R11 R21

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pin_q <= '0; // R16
            resp_q <= '0;
            pace_sel_q <= 4'h0;
            pace_pwr_q <= 1'b0;
        end else if (wr_en) begin
            case (PADDR)
                `ADDR_PIN_CTRL: begin
                    pin_q.dir <= PWDATA[3:0]; // R13
                    // a level bit moves only where this write makes an output
                    for (int i = 0; i < 4; i++) begin
                        if (PWDATA[i]) begin
                            pin_q.level[i] <= PWDATA[4+i]; // R15
                        end
                    end
                end
                `ADDR_RESP_SET: begin
                    resp_q <= PWDATA[9:0]; // R4 R7 R8 R9
                end
                `ADDR_PACE_CTRL: begin
                    pace_sel_q <= PWDATA[4:1]; // R2
                    pace_pwr_q <= PWDATA[0]; // R3
                end
                default: begin
                end
            endcase
        end
    end

    // reads capture in the setup cycle so data is ready with the access
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            prdata_q <= 32'h0;
        end else if (rd_en) begin
            case (PADDR)
                `ADDR_PIN_CTRL: prdata_q <= {24'h0, pin_now, pin_q.dir}; // R14
                `ADDR_RESP_SET: prdata_q <= {22'h0, resp_q};
                `ADDR_PACE_CTRL: prdata_q <= {27'h0, pace_sel_q, pace_pwr_q};
                `ADDR_STATUS: prdata_q <= {29'h0, FILTER_SETTLED,
                    CH1_RESP_ONLY, clk_lvl_q};
                `ADDR_FRAME: prdata_q <= {28'h0, frame_q};
                default: prdata_q <= 32'h0;
            endcase
        end
    end

    assign PACE_CHAN_SEL = pace_sel_q; // R2
    assign PACE_AMP_POWER = pace_pwr_q; // R3

    // ---------------------------------------------------------------
    // respiration clock generation
    // ---------------------------------------------------------------
    logic [9:0] div_q;
    logic [3:0] step_q;
    logic mod_q, demod_q;
    logic [9:0] half_cnt;
    logic [3:0] phase_steps;
    logic demod_sig, std_freq;

    assign std_freq = (resp_q.freq == `FREQ_64K)
        || (resp_q.freq == `FREQ_32K); // R7
    assign half_cnt = (resp_q.freq == `FREQ_64K) ? 10'(HALF64 / 8)
        : 10'(HALF32 / 8); // R7
    // phase code n gives (n+1)*22.5 degrees, one sixteenth period per step
    assign phase_steps = {1'b0, resp_q.phase} + 4'h1; // R8

    // sixteen sub-steps per period; hold off in disabled mode saves power
    always_ff @(posedge CORE_CLK) begin
        if (RST || resp_q.mode == `MODE_OFF) begin
            div_q <= 10'h0;
            step_q <= 4'h0;
        end else if (CLK_EN) begin
            if (div_q >= half_cnt - 10'h1) begin
                div_q <= 10'h0;
                step_q <= step_q + 4'h1;
            end else begin
                div_q <= div_q + 10'h1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mod_q <= 1'b0;
            demod_q <= 1'b0;
        end else if (CLK_EN) begin
            mod_q <= step_q[3];
            demod_q <= demod_sig; // R8
        end
    end
    // demodulation rises phase_steps sub-steps after modulation rises
    assign demod_sig = 4'(step_q - phase_steps) >= 4'h8; // R8

    assign MOD_BLOCK_EN = resp_q.mode == `MODE_INT && resp_q.mod_en; // R9
    assign DEMOD_BLOCK_EN = resp_q.mode == `MODE_INT
        && resp_q.demod_en; // R9
    assign CH1_RESP_ONLY = resp_q.mode == `MODE_INT; // R10

    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    logic [3:0] pin_out_q, pin_oe_q;

    // direction: gpio bits unless a respiration mode owns the pin
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pin_oe_q <= 4'h0; // R16
        end else if (CLK_EN) begin
            pin_oe_q <= pin_q.dir & ~forced_mask; // R13 R21
            case (resp_q.mode)
                `MODE_EXT: pin_oe_q[3:1] <= 3'b111; // R5
                `MODE_USER: pin_oe_q[3:1] <= 3'b000; // R11
                default: begin
                end
            endcase
        end
    end

    // drive value; both clocks come from flops so the xor has no skew
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pin_out_q <= 4'h0;
        end else if (CLK_EN) begin
            pin_out_q <= pin_q.level;
            if (resp_q.mode == `MODE_EXT) begin
                pin_out_q[2] <= mod_q; // R6
                pin_out_q[3] <= demod_q; // R6
                pin_out_q[1] <= std_freq & (mod_q ^ demod_q); // R6 R7
            end
        end
    end
    assign PIN_OUT = pin_out_q;
    assign PIN_OE = pin_oe_q;
    // outputs read back as driven, inputs as sampled
    assign pin_now = (pin_oe_q & pin_out_q) | (~pin_oe_q & pin_lvl_q); // R14

    // ---------------------------------------------------------------
    // frame sampling and filter settling
    // ---------------------------------------------------------------
    // ready arrives through the synchroniser; the frame takes the levels
    // held a fixed number of clocks before the falling edge is seen
    logic [3:0] hist_q [LATCH_CLKS];
    logic rdy_prev_q;
    logic rdy_fall;
    settle_e st_q;
    logic [31:0] settle_q;
    logic resp_wr;

    assign rdy_fall = rdy_prev_q && !rdy_lvl_q;
    assign resp_wr = reg_hit(wr_en, PADDR, `ADDR_RESP_SET);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdy_prev_q <= 1'b1;
            for (int k = 0; k < LATCH_CLKS; k++) begin
                hist_q[k] <= 4'h0;
            end
        end else if (CLK_EN) begin
            rdy_prev_q <= rdy_lvl_q;
            hist_q[0] <= pin_now;
            for (int k = 1; k < LATCH_CLKS; k++) begin
                hist_q[k] <= hist_q[k-1];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            frame_q <= 4'h0;
        end else if (CLK_EN && rdy_fall) begin
            frame_q <= hist_q[LATCH_CLKS-1]; // R1
        end
    end

    // settle timer restarts whenever respiration settings change
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_q <= SET_IDLE;
            settle_q <= 32'h0;
        end else if (CLK_EN) begin
            case (st_q)
                SET_IDLE: begin
                    settle_q <= 32'(SETTLE_CLKS * `SETTLE_PERIODS); // R19
                    st_q <= SET_WAIT;
                end
                SET_WAIT: begin
                    // a write at expiry restarts, so settled is never stale
                    if (resp_wr) begin
                        st_q <= SET_IDLE;
                    end else if (settle_q == 32'h1) begin
                        st_q <= SET_DONE;
                    end else begin
                        settle_q <= settle_q - 32'h1;
                    end
                end
                SET_DONE: begin
                    if (resp_wr) begin
                        st_q <= SET_IDLE;
                    end
                end
                default: st_q <= SET_IDLE;
            endcase
        end
    end
    assign FILTER_SETTLED = st_q == SET_DONE; // R19
endmodule : gpio_resp_pace
`default_nettype wire

// ---- include/gpio_resp_params.svh ----
// constants for the gpio and respiration pace control block
// assumes a 20 MHz core clock and a 32-bit apb register bus
//
// Notes on behaviour
// (R1) pin levels latch into the frame two clocks before ready falls
// (R2) four-bit field picks one odd and one even channel for pace
// (R3) pace amplifier power follows its bit; software turns unused ones off
// (R4) two-bit mode field picks disabled, external, internal or user input
// (R5) external mode forces pins two to four to outputs
// (R6) external mode: pin three modulation, four demodulation, two their xor
// (R7) frequency field gives 64 or 32 kHz; other codes square waves, no xor
// (R8) three-bit phase field delays demodulation 22.5 to 157.5 degrees; code 7 here gives 180 degrees
// (R9) internal mode enables modulation and demodulation blocks separately
// (R10) internal mode leaves pins to gpio and dedicates channel one
// (R11) user mode forces pins two to four to inputs
// (R12) software must not pick user mode with internal oscillator selected
// (R13) each pin has its own direction bit
// (R14) reading levels returns the actual pin levels
// (R15) level write ignored on inputs, drives value on outputs
// (R16) all pins are inputs after reset
// (R17) outside party drives every input pin, never floating
// (R18) software pace detection should run at 8 kSPS or more
// (R19) filter output needs three data periods to settle after a step
// (R20) clock source pin low picks external clock, high internal
// (R21) disabled or internal mode return pins to direction and level bits
`ifndef GPIO_RESP_PARAMS_SVH
`define GPIO_RESP_PARAMS_SVH

`define ADDR_PIN_CTRL 12'h000
`define ADDR_RESP_SET 12'h004
`define ADDR_PACE_CTRL 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_FRAME 12'h010

`define CORE_CLK_HZ 20000000
`define FREQ_64K_HZ 64000
`define FREQ_32K_HZ 32000
`define PHASE_STEPS 16
`define FRAME_LATCH_CLKS 2
`define SETTLE_PERIODS 3

`define MODE_OFF 2'h0
`define MODE_EXT 2'h1
`define MODE_INT 2'h2
`define MODE_USER 2'h3
`define FREQ_64K 3'h0
`define FREQ_32K 3'h1

`endif

// ---- include/gpio_resp_pkg.sv ----
// types for the gpio and respiration pace control block
// assumes the params header is included by users
package gpio_resp_pkg;
    typedef struct packed {
        logic [3:0] dir;
        logic [3:0] level;
    } pin_ctrl_s;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] freq;
        logic [2:0] phase;
        logic mod_en;
        logic demod_en;
    } resp_mode_sel_s;

    typedef enum logic [2:0] {
        SET_IDLE = 3'b001,
        SET_WAIT = 3'b010,
        SET_DONE = 3'b100
    } settle_e;
endpackage : gpio_resp_pkg

// ---- verification/gpio_resp_pace_asserts.sv ----
// port-level checks for the gpio respiration pace block
// assumes pins follow their registers two edges after an apb write
`timescale 1ns/10ps
`default_nettype none
module gpio_resp_pace_asserts #(
    parameter int SETTLE_CLKS = 5000
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [3:0] PIN_OUT,
    input wire logic [3:0] PIN_OE,
    input wire logic [3:0] PACE_CHAN_SEL,
    input wire logic PACE_AMP_POWER
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    logic wr;
    logic rsp;
    assign wr = PSEL && PENABLE && PWRITE && CLK_EN;
    assign rsp = wr && PADDR == 12'h004;
    chk_reset_inputs: assert property ($fell(RST) |-> PIN_OE == 4'h0)
        else $error("pins driven after reset");
    chk_ext_outputs: assert property ((rsp && PWDATA[9:8] == 2'h1)
        |-> ##2 PIN_OE[3:1] == 3'h7) else $error("ext pins not out");
    chk_user_inputs: assert property ((rsp && PWDATA[9:8] == 2'h3)
        |-> ##2 PIN_OE[3:1] == 3'h0) else $error("user pins not in");
    chk_ext_xor: assert property ((rsp && PWDATA[9:8] == 2'h1
        && PWDATA[7:5] < 3'h2) |-> ##2 (PIN_OUT[1] ==
        (PIN_OUT[2] ^ PIN_OUT[3])) [*3]) else $error("xor pin wrong");
    chk_pace_sel: assert property ((wr && PADDR == 12'h008) |=>
        PACE_CHAN_SEL == $past(PWDATA[4:1])
        && PACE_AMP_POWER == $past(PWDATA[0])) else $error("pace wrong");
    chk_pin_dir: assert property ((wr && PADDR == 12'h000) |->
        ##2 PIN_OE[0] == $past(PWDATA[0], 2)) else $error("dir wrong");
    chk_pin_level: assert property ((wr && PADDR == 12'h000
        && PWDATA[0]) |-> ##2 PIN_OUT[0] == $past(PWDATA[4], 2))
        else $error("level wrong");
    chk_bad_addr: assert property ((PSEL && PENABLE
        && PADDR > 12'h010) |-> PSLVERR) else $error("no slave error");
    chk_ready_now: assert property ((PSEL && PENABLE) |-> PREADY)
        else $error("access stalled");
    cov_ext: cover property (rsp && PWDATA[9:8] == 2'h1);
    cov_user: cover property (rsp && PWDATA[9:8] == 2'h3);
    cov_err: cover property (PSEL && PENABLE && PSLVERR);
endmodule : gpio_resp_pace_asserts
bind gpio_resp_pace gpio_resp_pace_asserts #(.SETTLE_CLKS(SETTLE_CLKS)) i_chk (
    .CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PACE_CHAN_SEL(PACE_CHAN_SEL), .PACE_AMP_POWER(PACE_AMP_POWER));
`default_nettype wire

// ---- verification/pin_partner.sv ----
// outside circuitry on the four general-purpose pins
// assumes the bench sets drive_val; never lets an input pin float
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
    input wire logic [3:0] drive_val,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pin_out,
    output logic [3:0] pin_level
);
    // wire level: device wins where it drives, else our drive
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & drive_val);
endmodule : pin_partner
`default_nettype wire

// ---- verification/gpio_resp_pace_test.sv ----
// self-checking bench for the gpio respiration pace block
// assumes the checker is bound in and the partner drives the pins
`timescale 1ns/10ps
`default_nettype none
module gpio_resp_pace_test;
    logic CORE_CLK, RST, CLK_EN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, d;
    logic [3:0] PIN_IN, PIN_OUT, PIN_OE, PACE_CHAN_SEL, drv;
    logic CLK_SOURCE_PIN, CONVERSION_READY_N, PACE_AMP_POWER;
    logic MOD_BLOCK_EN, DEMOD_BLOCK_EN, CH1_RESP_ONLY;
    logic INT_OSC_SEL, FILTER_SETTLED;
    logic [1:0] m;
    logic [63:0] e;
    logic [63:0] exp_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int i;
    // small data period keeps the settle wait short
    gpio_resp_pace #(.SETTLE_CLKS(4)) i_dut (
        .CORE_CLK(CORE_CLK), .RST(RST),
        .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
        .PIN_OE(PIN_OE), .CLK_SOURCE_PIN(CLK_SOURCE_PIN),
        .CONVERSION_READY_N(CONVERSION_READY_N),
        .PACE_CHAN_SEL(PACE_CHAN_SEL), .PACE_AMP_POWER(PACE_AMP_POWER),
        .MOD_BLOCK_EN(MOD_BLOCK_EN), .DEMOD_BLOCK_EN(DEMOD_BLOCK_EN),
        .CH1_RESP_ONLY(CH1_RESP_ONLY), .INT_OSC_SEL(INT_OSC_SEL),
        .FILTER_SETTLED(FILTER_SETTLED));
    pin_partner i_far (.drive_val(drv), .pin_oe(PIN_OE),
        .pin_out(PIN_OUT), .pin_level(PIN_IN));
    always #25 CORE_CLK = ~CORE_CLK;
    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask : check
    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // reads note expected data and mask; writes note nothing
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] v, input logic [31:0] k);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= v;
        if (!w) exp_q.push_back({k, v});
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (!PREADY);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    always @(posedge CORE_CLK) begin
        if (PSEL && PENABLE && !PWRITE && PREADY) begin
            e = exp_q.pop_front();
            check(PRDATA & e[63:32], e[31:0]);
            check(32'(PSLVERR), 32'(PADDR > 12'h010));
        end
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        CORE_CLK = 0;
        RST = 1;
        CLK_EN = 1;
        PSEL = 0;
        PENABLE = 0;
        PWRITE = 0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        CLK_SOURCE_PIN = 0;
        CONVERSION_READY_N = 1;
        drv = 4'h5;
        void'($urandom(66));
        repeat (10) @(posedge CORE_CLK);
        RST <= 1'b0;
        repeat (8) @(posedge CORE_CLK);
        apb(0, 12'h000, 32'h50, 32'hFF);
        for (i = 0; i < 8; i++) begin
            d = $urandom;
            drv <= d[11:8];
            apb(1, 12'h000, {24'h0, d[7:0]}, 32'h0);
            repeat (8) @(posedge CORE_CLK);
            apb(0, 12'h000, {24'h0, (d[3:0] & d[7:4]) | (~d[3:0] & d[11:8]),
                d[3:0]}, 32'hFF);
        end
        d = $urandom;
        apb(1, 12'h008, d, 32'h0);
        apb(0, 12'h008, {27'h0, d[4:0]}, 32'h1F);
        check(PACE_CHAN_SEL, d[4:1]);
        check(PACE_AMP_POWER, d[0]);
        apb(1, 12'h000, 32'h0, 32'h0);
        drv <= d[8:5];
        repeat (8) @(posedge CORE_CLK);
        CONVERSION_READY_N <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        CONVERSION_READY_N <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        apb(0, 12'h010, {28'h0, d[8:5]}, 32'hF);
        apb(1, 12'h000, 32'h0A, 32'h0);
        // mode order 1,0,3,2 so every return to gpio follows a takeover
        for (i = 0; i < 4; i++) begin
            m = 2'(i) ^ 2'h1;
            apb(1, 12'h004, {22'h0, m, 3'h0, 3'(i), 2'h2}, 32'h0);
            repeat (3) @(posedge CORE_CLK);
            #1;
            check(PIN_OE[3:1], m == 1 ? 3'h7 : m == 3 ? 3'h0 : 3'h5);
            check(CH1_RESP_ONLY, m == 2);
        end
        check(MOD_BLOCK_EN, 1);
        check(DEMOD_BLOCK_EN, 0);
        check(FILTER_SETTLED, 0);
        repeat (20) @(posedge CORE_CLK);
        #1;
        check(FILTER_SETTLED, 1);
        @(posedge CORE_CLK);
        CLK_SOURCE_PIN <= 1'b1;
        repeat (8) @(posedge CORE_CLK);
        apb(0, 12'h00C, 32'h3, 32'h3);
        check(INT_OSC_SEL, 1);
        apb(0, 12'h020, 32'h0, 32'hFFFFFFFF);
        repeat (2) @(posedge CORE_CLK);
        wrap_up();
    end
endmodule : gpio_resp_pace_test
`default_nettype wire
